// [src/cic_pkg.sv]
package cic_pkg;
   // receiver flag / enable layout
   localparam int RF_WAKE = 7;
   localparam int RF_SCHG = 6;
   localparam int RF_RX_STATE_FIELD = 4;
   localparam int RF_TX_STATE_FIELD = 2;
   localparam int RF_OVR = 1;
   localparam int RF_RXF = 0;
   localparam logic [7:0] RF_ERR_MASK = 8'h42;
   localparam logic [7:0] RF_FLAG_MASK = 8'hc3;
   localparam logic [7:0] RF_RST = 8'h00;
   localparam int N_TX = 3;
   localparam int ST_W = 2;
   localparam logic [N_TX-1:0] TX_EMPTY_RST = 3'h7;
   // init handshake delay: bus-side plus engine-side stages
   localparam int INIT_BUS_SYNC = 2;
   localparam int INIT_CAN_SYNC = 3;
   localparam int INIT_SYNC_CYCLES = INIT_BUS_SYNC + INIT_CAN_SYNC;
   localparam int CNT_W = 3;
   // host register map (byte addresses)
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STAT = 8'h04;
   localparam logic [7:0] A_RXIE = 8'h08;
   localparam logic [7:0] A_TXIE = 8'h0c;
   localparam logic [7:0] A_RXFLG = 8'h10;
   localparam logic [7:0] A_TXFLG = 8'h14;
   localparam int C_EN = 0;
   localparam int C_SLP = 1;
   localparam int C_INIT = 2;
   localparam int C_WAKE_ON_BUS_EN = 3;
   localparam logic [3:0] CTRL_RST = 4'h4;
   localparam int S_SLEEP_ACK = 0;
   localparam int S_INIT_ACK = 1;

   typedef enum logic [1:0] {
      CIC_RUN = 2'b00,
      CIC_SLEEP = 2'b01,
      CIC_SYNC = 2'b10,
      CIC_INIT = 2'b11
   } cic_mode_t;

   function automatic logic cic_any(input logic [7:0] f, input logic [7:0] e,
                                    input logic [7:0] m);
      return |(f & e & m);
   endfunction
endpackage

// [src/cic_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface cic_if;
   import cic_pkg::*;
   logic module_enable;
   logic sleep_request;
   logic init_request;
   logic wake_on_bus_en;
   logic [7:0] rx_irq_enable_reg;
   logic [N_TX-1:0] tx_irq_enable_reg;
   logic [7:0] rx_clr;
   logic [N_TX-1:0] tx_clr;
   logic sleep_ack;
   logic init_ack;
   logic [7:0] rx_flag_reg;
   logic [N_TX-1:0] tx_flag_reg;
   logic irq_wake;
   logic irq_err;
   logic irq_rx;
   logic irq_tx;

   modport dev (
      input module_enable, sleep_request, init_request, wake_on_bus_en,
      input rx_irq_enable_reg, tx_irq_enable_reg, rx_clr, tx_clr,
      output sleep_ack, init_ack, rx_flag_reg, tx_flag_reg,
      output irq_wake, irq_err, irq_rx, irq_tx
   );
   modport host (
      output module_enable, sleep_request, init_request, wake_on_bus_en,
      output rx_irq_enable_reg, tx_irq_enable_reg, rx_clr, tx_clr,
      input sleep_ack, init_ack, rx_flag_reg, tx_flag_reg,
      input irq_wake, irq_err, irq_rx, irq_tx
   );
endinterface
`default_nettype wire

// [src/cic_flags.sv]
`timescale 1ns/1ps
`default_nettype none
module cic_flags #(
   parameter int W = 8,
   parameter logic [W-1:0] RST = '0
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   // control
   input wire logic init,
   input wire logic [W-1:0] set,
   input wire logic [W-1:0] clr,
   // state
   output logic [W-1:0] q
);
   logic [W-1:0] q_reg;
   logic [W-1:0] q_next;

   // set also acts as the persisting condition: it beats a clear
   always_comb begin
      if (init) begin
         q_next = RST;
      end else begin
         q_next = set | (q_reg & ~clr);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q_reg <= RST;
      end else if (ce) begin
         q_reg <= q_next;
      end
   end

   assign q = q_reg;
endmodule
`default_nettype wire

// [src/cic_dev.sv]
`timescale 1ns/1ps
`default_nettype none
module cic_dev (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   // host side
   cic_if.dev bus,
   // protocol engine side
   input wire logic bus_activity,
   input wire logic bus_idle,
   input wire logic [cic_pkg::N_TX-1:0] tx_done,
   input wire logic rx_fg_loaded,
   input wire logic rx_overrun,
   input wire logic [cic_pkg::ST_W-1:0] tx_err_state,
   input wire logic [cic_pkg::ST_W-1:0] rx_err_state,
   input wire logic power_down,
   output logic [cic_pkg::N_TX-1:0] tx_empty_flags,
   output logic sleep_mode,
   output logic abort_xfer,
   output logic tx_recessive,
   output logic cpu_wake
);
   import cic_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // mode sequencing
   cic_mode_t mode_reg;
   cic_mode_t mode_next;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic init_s1_reg;
   logic init_s2_reg;
   logic pd_reg;
   logic pd_next;
   logic pd_slept_reg;
   logic pd_slept_next;
   logic woke_reg;
   logic woke_next;
   logic wake_set;
   logic all_empty;
   logic [N_TX-1:0] tx_q;

   assign all_empty = &tx_q;
   assign wake_set = (mode_reg == CIC_SLEEP) && bus.wake_on_bus_en && bus_activity;

   always_comb begin
      mode_next = mode_reg;
      cnt_next = cnt_reg;
      pd_next = power_down;
      pd_slept_next = pd_slept_reg;
      woke_next = woke_reg;
      if (power_down && !pd_reg) begin
         pd_slept_next = (mode_reg == CIC_SLEEP);
      end
      case (mode_reg)
         CIC_RUN: begin
            if (init_s2_reg) begin
               mode_next = CIC_SYNC;
               cnt_next = '0;
            // after a wake-up, stay awake until the host drops its request
            end else if (bus.sleep_request && bus_idle && all_empty && !woke_reg) begin
               mode_next = CIC_SLEEP;
            end
         end
         CIC_SLEEP: begin
            if (init_s2_reg) begin
               mode_next = CIC_SYNC;
               cnt_next = '0;
            end else if (!bus.sleep_request || wake_set) begin
               mode_next = CIC_RUN;
               woke_next = wake_set;
            end
         end
         CIC_SYNC: begin
            // request cannot be withdrawn until acknowledged
            if (cnt_reg == CNT_W'(INIT_SYNC_CYCLES - 1)) begin
               mode_next = CIC_INIT;
            end else begin
               cnt_next = cnt_reg + 1'b1;
            end
         end
         CIC_INIT: begin
            if (!init_s2_reg) begin
               mode_next = CIC_RUN;
            end
         end
         default: begin
            mode_next = CIC_SYNC;
            cnt_next = '0;
         end
      endcase
      if (!bus.sleep_request) begin
         woke_next = 1'b0;
      end
      if (!bus.module_enable) begin
         mode_next = CIC_SYNC;
         cnt_next = '0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_reg <= CIC_SYNC;
         cnt_reg <= '0;
         init_s1_reg <= 1'b0;
         init_s2_reg <= 1'b0;
         pd_reg <= 1'b0;
         pd_slept_reg <= 1'b0;
         woke_reg <= 1'b0;
      end else if (ce) begin
         mode_reg <= mode_next;
         cnt_reg <= cnt_next;
         init_s1_reg <= bus.init_request;
         init_s2_reg <= init_s1_reg;
         pd_reg <= pd_next;
         pd_slept_reg <= pd_slept_next;
         woke_reg <= woke_next;
      end
   end

   logic in_init;
   assign in_init = (mode_reg == CIC_SYNC) || (mode_reg == CIC_INIT);
   assign bus.sleep_ack = (mode_reg == CIC_SLEEP);
   assign bus.init_ack = (mode_reg == CIC_INIT);
   assign sleep_mode = (mode_reg == CIC_SLEEP);
   assign abort_xfer = in_init;
   // sleep and power down also keep the line quiet
   assign tx_recessive = in_init || sleep_mode || power_down;

   ////////////////////////////////////////////////////////////////////////
   // error state tracking
   logic [ST_W-1:0] tst_reg;
   logic [ST_W-1:0] tst_next;
   logic [ST_W-1:0] rst_reg;
   logic [ST_W-1:0] rst_next;
   logic [ST_W-1:0] tprev_reg;
   logic [ST_W-1:0] rprev_reg;
   logic schg_set;

   // any move into a non-ok range counts as a status change
   assign schg_set = !in_init &&
                     (((tx_err_state != tprev_reg) && (tx_err_state != '0)) ||
                      ((rx_err_state != rprev_reg) && (rx_err_state != '0)));

   always_comb begin
      tst_next = tst_reg;
      rst_next = rst_reg;
      if (in_init) begin
         tst_next = '0;
         rst_next = '0;
      end else if (schg_set) begin
         tst_next = tx_err_state;
         rst_next = rx_err_state;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tst_reg <= '0;
         rst_reg <= '0;
         tprev_reg <= '0;
         rprev_reg <= '0;
      end else if (ce) begin
         tst_reg <= tst_next;
         rst_reg <= rst_next;
         tprev_reg <= tx_err_state;
         rprev_reg <= rx_err_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // status flags
   logic [7:0] rx_set;
   logic [7:0] rx_q;
   logic rxf_set;
   logic [N_TX-1:0] tx_set;

   // no foreground shift happens while asleep
   assign rxf_set = rx_fg_loaded && !sleep_mode && !in_init;

   always_comb begin
      rx_set = 8'h00;
      rx_set[RF_WAKE] = wake_set;
      rx_set[RF_SCHG] = schg_set;
      rx_set[RF_OVR] = rx_overrun && !in_init;
      rx_set[RF_RXF] = rxf_set;
      tx_set = in_init ? '0 : tx_done;
   end

   // clear strobes only come from write-one accesses
   cic_flags #(
      .W(8),
      .RST(RF_RST)
   ) u_rx_flags (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .init(in_init),
      .set(rx_set),
      .clr(bus.rx_clr & RF_FLAG_MASK),
      .q(rx_q)
   );

   cic_flags #(
      .W(N_TX),
      .RST(TX_EMPTY_RST)
   ) u_tx_flags (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .init(in_init),
      .set(tx_set),
      .clr(bus.tx_clr),
      .q(tx_q)
   );

   always_comb begin
      bus.rx_flag_reg = rx_q & RF_FLAG_MASK;
      bus.rx_flag_reg[RF_RX_STATE_FIELD +: ST_W] = rst_reg;
      bus.rx_flag_reg[RF_TX_STATE_FIELD +: ST_W] = tst_reg;
   end
   assign bus.tx_flag_reg = tx_q;
   assign tx_empty_flags = tx_q;

   ////////////////////////////////////////////////////////////////////////
   // interrupt requests, level while any enabled flag stands
   assign bus.irq_wake = cic_any(rx_q, bus.rx_irq_enable_reg, 8'h01 << RF_WAKE);
   assign bus.irq_err = cic_any(rx_q, bus.rx_irq_enable_reg, RF_ERR_MASK);
   assign bus.irq_rx = cic_any(rx_q, bus.rx_irq_enable_reg, 8'h01 << RF_RXF);
   assign bus.irq_tx = cic_any({5'h00, tx_q}, {5'h00, bus.tx_irq_enable_reg},
                               {5'h00, TX_EMPTY_RST});
   // only a sleep acknowledged before power down may wake the cpu
   assign cpu_wake = power_down && pd_slept_reg && bus.wake_on_bus_en &&
                     bus.irq_wake;
endmodule
`default_nettype wire

// [src/cic_host.sv]
`timescale 1ns/1ps
`default_nettype none
module cic_host (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // cpu interrupt lines: wake, error, receive, transmit
   output logic [3:0] irq_req,
   // device side
   cic_if.host dev
);
   import cic_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // bus phases
   logic take;
   logic wpend_reg;
   logic [7:0] waddr_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic [3:0] ctrl_reg;
   logic [7:0] rxie_reg;
   logic [N_TX-1:0] txie_reg;

   // hsize is always a word here
   assign take = ce && hsel && htrans[1] && hready;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_reg;

   always_comb begin
      rdata_next = rdata_reg;
      if (take && !hwrite) begin
         case (haddr[7:0])
            A_CTRL: rdata_next = {28'h0000000, ctrl_reg};
            A_STAT: rdata_next = {30'h0, dev.init_ack, dev.sleep_ack};
            A_RXIE: rdata_next = {24'h000000, rxie_reg};
            A_TXIE: rdata_next = {29'h0, txie_reg};
            A_RXFLG: rdata_next = {24'h000000, dev.rx_flag_reg};
            A_TXFLG: rdata_next = {29'h0, dev.tx_flag_reg};
            default: rdata_next = 32'h00000000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // software registers
   logic [3:0] ctrl_next;
   logic [7:0] rxie_next;
   logic [N_TX-1:0] txie_next;
   logic [7:0] rclr_next;
   logic [N_TX-1:0] tclr_next;
   logic [7:0] rclr_reg;
   logic [N_TX-1:0] tclr_reg;
   logic sleep_ack_d_reg;
   logic init_ack_d_reg;
   logic wr;

   assign wr = ce && wpend_reg;

   always_comb begin
      ctrl_next = ctrl_reg;
      rxie_next = rxie_reg;
      txie_next = txie_reg;
      rclr_next = 8'h00;
      tclr_next = '0;
      if (wr) begin
         case (waddr_reg)
            A_CTRL: begin
               ctrl_next = hwdata[3:0];
               // request bits stay until the handshake has completed
               // init mode ends the sleep handshake, so release is allowed there
               if (ctrl_reg[C_SLP] && !dev.sleep_ack && !dev.init_ack) begin
                  ctrl_next[C_SLP] = 1'b1;
               end
               if (ctrl_reg[C_INIT] && !dev.init_ack) begin
                  ctrl_next[C_INIT] = 1'b1;
               end
            end
            A_RXIE: rxie_next = hwdata[7:0];
            A_TXIE: txie_next = hwdata[N_TX-1:0];
            A_RXFLG: rclr_next = hwdata[7:0];
            A_TXFLG: tclr_next = hwdata[N_TX-1:0];
            default: ctrl_next = ctrl_reg;
         endcase
      end
      // a bus wake-up ends sleep without software
      if (sleep_ack_d_reg && !dev.sleep_ack && !dev.init_ack && !ctrl_reg[C_INIT]) begin
         ctrl_next[C_SLP] = 1'b0;
      end
      // entering init returns the enables to their defaults
      if (dev.init_ack && !init_ack_d_reg) begin
         rxie_next = 8'h00;
         txie_next = '0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wpend_reg <= 1'b0;
         waddr_reg <= 8'h00;
         rdata_reg <= 32'h00000000;
         ctrl_reg <= CTRL_RST;
         rxie_reg <= 8'h00;
         txie_reg <= '0;
         rclr_reg <= 8'h00;
         tclr_reg <= '0;
         sleep_ack_d_reg <= 1'b0;
         init_ack_d_reg <= 1'b0;
      end else if (ce) begin
         wpend_reg <= take && hwrite;
         waddr_reg <= haddr[7:0];
         rdata_reg <= rdata_next;
         ctrl_reg <= ctrl_next;
         rxie_reg <= rxie_next;
         txie_reg <= txie_next;
         rclr_reg <= rclr_next;
         tclr_reg <= tclr_next;
         sleep_ack_d_reg <= dev.sleep_ack;
         init_ack_d_reg <= dev.init_ack;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // device side
   assign dev.module_enable = ctrl_reg[C_EN];
   assign dev.sleep_request = ctrl_reg[C_SLP];
   assign dev.init_request = ctrl_reg[C_INIT];
   assign dev.wake_on_bus_en = ctrl_reg[C_WAKE_ON_BUS_EN];
   assign dev.rx_irq_enable_reg = rxie_reg;
   assign dev.tx_irq_enable_reg = txie_reg;
   // one-cycle strobes, only the bits written as one
   assign dev.rx_clr = rclr_reg;
   assign dev.tx_clr = tclr_reg;
   assign irq_req = {dev.irq_wake, dev.irq_err, dev.irq_rx, dev.irq_tx};
endmodule
`default_nettype wire

// [tb/cic_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module cic_chk
   import cic_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // host controls
   input wire logic module_enable,
   input wire logic sleep_request,
   input wire logic init_request,
   input wire logic [7:0] rx_irq_enable_reg,
   input wire logic [N_TX-1:0] tx_irq_enable_reg,
   input wire logic [7:0] rx_clr,
   input wire logic [N_TX-1:0] tx_clr,
   // device status
   input wire logic sleep_ack,
   input wire logic init_ack,
   input wire logic [7:0] rx_flag_reg,
   input wire logic [N_TX-1:0] tx_flag_reg,
   input wire logic irq_wake,
   input wire logic irq_err,
   input wire logic irq_rx,
   input wire logic irq_tx
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic [3:0] req_run;
   // consecutive cycles with an enabled init request
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req_run <= 4'h0;
      end else if (!(init_request && module_enable)) begin
         req_run <= 4'h0;
      end else if (req_run != 4'hf) begin
         req_run <= req_run + 4'h1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   AST_IRQ_TX: assert property (irq_tx == |(tx_flag_reg & tx_irq_enable_reg))
      else $error("transmit request mismatch");
   AST_IRQ_RX: assert property (irq_rx == (rx_flag_reg[0] & rx_irq_enable_reg[0]))
      else $error("receive request mismatch");
   AST_IRQ_ERR: assert property (irq_err == |(rx_flag_reg & rx_irq_enable_reg & 8'h42))
      else $error("error request mismatch");
   AST_IRQ_WAKE: assert property (irq_wake == (rx_flag_reg[7] & rx_irq_enable_reg[7]))
      else $error("wake request mismatch");
   AST_RX_W1C: assert property (|($past(rx_flag_reg) & ~rx_flag_reg & RF_FLAG_MASK
      & ~$past(rx_clr)) |-> $past(init_request))
      else $error("receive flag dropped without clear");
   AST_TX_W1C: assert property (|($past(tx_flag_reg) & ~tx_flag_reg & ~$past(tx_clr))
      |-> $past(init_request))
      else $error("transmit flag dropped without clear");
   AST_INIT_MIN: assert property ($rose(init_ack) |-> req_run >= INIT_SYNC_CYCLES)
      else $error("init ack too early");
   AST_INIT_BOUND: assert property ($rose(init_request && module_enable)
      |-> ##[1:16] init_ack)
      else $error("init ack missing");
   AST_INIT_HOLD: assert property (init_request && !init_ack |=> init_request)
      else $error("init request dropped before ack");
   AST_SLP_REQ: assert property ($rose(sleep_ack) |-> sleep_request)
      else $error("sleep ack without request");
   AST_SLP_DROP: assert property (sleep_ack && !sleep_request |=> !sleep_ack)
      else $error("sleep ack outlived request");
   cover property ($rose(init_ack));
   cover property ($rose(sleep_ack));
   cover property ($rose(irq_err));
endmodule
`default_nettype wire

// [tb/can_interrupt_and_init_ctrl_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module can_interrupt_and_init_ctrl_bench;
   import cic_pkg::*;
   typedef struct packed {
      logic receive_foreground_buffer; logic ovr; logic [2:0] txd; logic [1:0] tst; logic [1:0] rst;
      logic [7:0] rxie; logic [2:0] txie; logic [3:0] irq; logic [7:0] receive_full_flag; logic [2:0] txf;
   } cic_row_t;
   // event, enables, then expected requests and flags
   localparam cic_row_t ROWS [7] = '{
      '{1'b1, 1'b0, 3'h0, 2'h0, 2'h0, 8'h01, 3'h0, 4'h2, 8'h01, 3'h0},
      '{1'b1, 1'b0, 3'h0, 2'h0, 2'h0, 8'h00, 3'h0, 4'h0, 8'h01, 3'h0},
      '{1'b0, 1'b1, 3'h0, 2'h0, 2'h0, 8'h02, 3'h0, 4'h4, 8'h02, 3'h0},
      '{1'b0, 1'b0, 3'h2, 2'h0, 2'h0, 8'h00, 3'h2, 4'h1, 8'h00, 3'h2},
      '{1'b0, 1'b0, 3'h4, 2'h0, 2'h0, 8'h00, 3'h2, 4'h0, 8'h00, 3'h4},
      '{1'b0, 1'b0, 3'h0, 2'h1, 2'h0, 8'h40, 3'h0, 4'h4, 8'h44, 3'h0},
      '{1'b0, 1'b0, 3'h0, 2'h1, 2'h2, 8'h40, 3'h0, 4'h4, 8'h64, 3'h0}};
   logic hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, d;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [3:0] irq_req;
   logic bus_activity, bus_idle, rx_fg_loaded, rx_overrun, power_down;
   logic [N_TX-1:0] tx_done, tx_empty_flags;
   logic [ST_W-1:0] tx_err_state, rx_err_state;
   logic sleep_mode, abort_xfer, tx_recessive, cpu_wake;
   int num_errors = 0;
   int compares = 0;
   int cycles = 0;
   cic_row_t r;
   cic_if bus_if();
   cic_dev cic_dev_inst(.hclk(hclk), .hresetn(hresetn), .ce(ce), .bus(bus_if),
      .bus_activity(bus_activity), .bus_idle(bus_idle), .tx_done(tx_done),
      .rx_fg_loaded(rx_fg_loaded), .rx_overrun(rx_overrun), .tx_err_state(tx_err_state),
      .rx_err_state(rx_err_state), .power_down(power_down), .tx_empty_flags(tx_empty_flags),
      .sleep_mode(sleep_mode), .abort_xfer(abort_xfer), .tx_recessive(tx_recessive),
      .cpu_wake(cpu_wake));
   cic_host cic_host_inst(.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq_req(irq_req), .dev(bus_if));
   cic_chk cic_chk_inst(.hclk(hclk), .hresetn(hresetn),
      .module_enable(bus_if.module_enable), .sleep_request(bus_if.sleep_request),
      .init_request(bus_if.init_request), .rx_irq_enable_reg(bus_if.rx_irq_enable_reg),
      .tx_irq_enable_reg(bus_if.tx_irq_enable_reg), .rx_clr(bus_if.rx_clr),
      .tx_clr(bus_if.tx_clr), .sleep_ack(bus_if.sleep_ack), .init_ack(bus_if.init_ack),
      .rx_flag_reg(bus_if.rx_flag_reg), .tx_flag_reg(bus_if.tx_flag_reg),
      .irq_wake(bus_if.irq_wake), .irq_err(bus_if.irq_err), .irq_rx(bus_if.irq_rx),
      .irq_tx(bus_if.irq_tx));
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   // hang guard, well above the few hundred cycles the run needs
   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // entered just after a rising edge; both phases wait for hready
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      d = hrdata;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                     input string nm);
      // clear strobes land one edge after the write completes
      @(posedge hclk);
      ahb(1'b0, a, 32'h0);
      chk(nm, d & m, e);
   endtask
   task automatic wait_stat(input logic [31:0] m, input logic [31:0] e);
      for (int i = 0; i < 40; i++) begin
         ahb(1'b0, A_STAT, 32'h0);
         if ((d & m) === e) break;
      end
      chk("status", d & m, e);
   endtask
   task automatic pulse(input logic f, input logic o, input logic [2:0] t);
      rx_fg_loaded <= f;
      rx_overrun <= o;
      tx_done <= t;
      @(posedge hclk);
      rx_fg_loaded <= 1'b0;
      rx_overrun <= 1'b0;
      tx_done <= 3'h0;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {hsel, htrans, hwrite, haddr, hwdata, hresetn} = '0;
      {bus_activity, rx_fg_loaded, rx_overrun, power_down, tx_done} = '0;
      {tx_err_state, rx_err_state} = '0;
      hsize = 3'h2;
      ce = 1'b1;
      bus_idle = 1'b1;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      rd(A_CTRL, '1, 32'h4, "ctrl");
      rd(A_TXFLG, '1, 32'h7, "txflg");
      ahb(1'b1, A_CTRL, 32'h5);
      wait_stat(32'h2, 32'h2);
      ahb(1'b1, A_CTRL, 32'h1);
      wait_stat(32'h3, 32'h0);
      chk("abort", {31'h0, abort_xfer}, 32'h0);
      chk("hresp", {31'h0, hresp}, 32'h0);
      ahb(1'b1, A_TXFLG, 32'h7);
      $display("startup done");
      foreach (ROWS[i]) begin
         r = ROWS[i];
         ahb(1'b1, A_RXIE, {24'h0, r.rxie});
         ahb(1'b1, A_TXIE, {29'h0, r.txie});
         tx_err_state <= r.tst;
         rx_err_state <= r.rst;
         pulse(r.receive_foreground_buffer, r.ovr, r.txd);
         repeat (2) @(posedge hclk);
         chk("irq_req", {28'h0, irq_req}, {28'h0, r.irq});
         chk("tx_empty", {29'h0, tx_empty_flags}, {29'h0, r.txf});
         rd(A_RXFLG, '1, {24'h0, r.receive_full_flag}, "rxflg");
         rd(A_TXFLG, '1, {29'h0, r.txf}, "txflg");
         ahb(1'b1, A_RXFLG, 32'hff);
         ahb(1'b1, A_TXFLG, 32'h7);
         rd(A_RXFLG, 32'hc3, 32'h0, "rx_clear");
         rd(A_TXFLG, '1, 32'h0, "tx_clear");
         $display("row %0d done", i);
      end
      rd(8'h20, '1, 32'h0, "unmapped");
      // persisting overrun must survive both a one and a zero write
      rx_overrun <= 1'b1;
      ahb(1'b1, A_RXFLG, 32'h02);
      ahb(1'b1, A_RXFLG, 32'h00);
      rd(A_RXFLG, 32'hc3, 32'h02, "persist");
      rx_overrun <= 1'b0;
      ahb(1'b1, A_RXFLG, 32'h02);
      rd(A_RXFLG, 32'hc3, 32'h0, "released");
      $display("clear test done");
      pulse(1'b0, 1'b0, 3'h7);
      ahb(1'b1, A_CTRL, 32'hb);
      wait_stat(32'h3, 32'h1);
      chk("sleep_mode", {31'h0, sleep_mode}, 32'h1);
      ahb(1'b1, A_RXIE, 32'h80);
      power_down <= 1'b1;
      bus_activity <= 1'b1;
      @(posedge hclk);
      bus_activity <= 1'b0;
      repeat (2) @(posedge hclk);
      chk("irq_wake", {28'h0, irq_req}, 32'h8);
      chk("cpu_wake", {31'h0, cpu_wake}, 32'h1);
      power_down <= 1'b0;
      wait_stat(32'h3, 32'h0);
      ahb(1'b1, A_RXFLG, 32'h80);
      rd(A_RXFLG, 32'hc3, 32'h0, "wake_clr");
      $display("wake test done");
      ahb(1'b1, A_CTRL, 32'hb);
      wait_stat(32'h1, 32'h1);
      ahb(1'b1, A_CTRL, 32'hf);
      ahb(1'b1, A_CTRL, 32'hb);
      rd(A_CTRL, 32'h4, 32'h4, "early_clr");
      wait_stat(32'h2, 32'h2);
      chk("abort", {30'h0, abort_xfer, tx_recessive}, 32'h3);
      rd(A_RXIE, '1, 32'h0, "rxie_init");
      ahb(1'b1, A_CTRL, 32'h9);
      wait_stat(32'h3, 32'h0);
      chk("resume", {31'h0, abort_xfer}, 32'h0);
      $display("reconfig test done");
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rd(A_CTRL, '1, 32'h4, "ctrl_rst");
      rd(A_TXFLG, '1, 32'h7, "txflg_rst");
      chk("abort_rst", {31'h0, abort_xfer}, 32'h1);
      $display("reset test done");
      wrap_up();
   end
endmodule
`default_nettype wire
